// [sctr_pkg.sv]
// Constants shared by the socket command and trigger register logic.
package sctr_pkg;
   // Register interface widths.
   localparam int BANK_W = 2;
   localparam int SEL_W = 9;
   localparam int DATA_W = 32;
   // Bank numbers.
   localparam logic [1:0] BANK_CTRL = 2'h0;
   localparam logic [1:0] BANK_MAP = 2'h1;
   // Register select values inside the control bank.
   localparam logic [8:0] SEL_STATUS = 9'h000;
   localparam logic [8:0] SEL_SWTRIG = 9'h001;
   // Trigger allocation and the derived field widths.
   localparam int TRIG_COUNT = 16;
   localparam int TRIG_W = $clog2(TRIG_COUNT);
   localparam int ID_W = $clog2(TRIG_COUNT);
   // Command word field positions.
   localparam int CMD_LO = 0;
   localparam int CMD_HI = 7;
   localparam int BYTE_LO = 8;
   localparam int BYTE_HI = 15;
   localparam int WIDE_LO = 16;
   localparam int WIDE_HI = 31;
   // Status and trigger register bit positions.
   localparam int SHUT_BIT = 7;
   localparam int PEND_BIT = 31;
   // Command codes.
   localparam logic [7:0] CMD_SHUTDOWN = 8'h00;
   localparam logic [7:0] CMD_RESTART_QUIET = 8'h01;
   localparam logic [7:0] CMD_RESTART_STATUS = 8'h02;
   localparam logic [7:0] CMD_PROCEED = 8'h03;
   localparam logic [7:0] CMD_USER_CTRL = 8'h04;
   // Values after reset.
   localparam logic RST_SHUTDOWN = 1'b1;
   localparam logic RST_PENDING = 1'b0;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// [sctr_map_if.sv]
// Interface between the register front end and the trigger map bank.
`timescale 1ns/1ps
interface sctr_map_if;
   logic wrEn;                               // One-cycle write strobe.
   logic [sctr_pkg::SEL_W-1:0] sel;          // Entry selected by software.
   logic [sctr_pkg::DATA_W-1:0] wrData;      // Data of the write.
   logic [sctr_pkg::DATA_W-1:0] rdData;      // Read word for sel.
   logic [sctr_pkg::TRIG_W-1:0] lookupIdx;   // Trigger being looked up.
   logic [sctr_pkg::ID_W-1:0] lookupId;      // Module identifier it maps to.
   logic shutdown;                           // Manager is in shutdown.
   modport bank(input wrEn, sel, wrData, lookupIdx, shutdown, output rdData, lookupId);
   modport ctrl(output wrEn, sel, wrData, lookupIdx, shutdown, input rdData, lookupId);
endinterface

// [sctr_map_bank.sv]
// Trigger to module identifier mapping bank.
`timescale 1ns/1ps
module sctr_map_bank (
   input wire logic mclk,
   input wire logic rst_n,
   sctr_map_if.bank mapIf
);
   // One stored identifier per trigger; the first entry belongs to trigger 0.
   logic [sctr_pkg::ID_W-1:0] entry_q [sctr_pkg::TRIG_COUNT];
   logic [sctr_pkg::ID_W-1:0] entry_d [sctr_pkg::TRIG_COUNT];
   logic selInRange;

   // Entries beyond the allocation do not exist and behave as unused bits.
   assign selInRange = (mapIf.sel[sctr_pkg::SEL_W-1:sctr_pkg::TRIG_W] == '0);

   // Next state: a write lands only in shutdown, and only the low bits are kept.
   always_comb begin
      for (int i = 0; i < sctr_pkg::TRIG_COUNT; i++) begin
         entry_d[i] = entry_q[i];
      end
      if (mapIf.wrEn && mapIf.shutdown && selInRange) begin
         entry_d[mapIf.sel[sctr_pkg::TRIG_W-1:0]] = mapIf.wrData[sctr_pkg::ID_W-1:0];
      end
   end

   // Storage; reset clears every row, so duplicates and spare rows are legal.
   always_ff @(posedge mclk) begin
      for (int i = 0; i < sctr_pkg::TRIG_COUNT; i++) begin
         if (!rst_n) begin
            entry_q[i] <= '0;
         end else begin
            entry_q[i] <= entry_d[i];
         end
      end
   end

   // Read word: zero outside shutdown, upper bits always zero.
   always_comb begin
      mapIf.rdData = sctr_pkg::RST_WORD;
      if (mapIf.shutdown && selInRange) begin
         mapIf.rdData[sctr_pkg::ID_W-1:0] = entry_q[mapIf.sel[sctr_pkg::TRIG_W-1:0]];
      end
   end

   // The loader looks up row N for trigger N regardless of software gating.
   assign mapIf.lookupId = entry_q[mapIf.lookupIdx];
endmodule

// [sctr_socket_regs.sv]
// Register front end of one socket: command, status, software trigger and map access.
`timescale 1ns/1ps
module sctr_socket_regs (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [sctr_pkg::BANK_W-1:0] regBank,
   input wire logic [sctr_pkg::SEL_W-1:0] regSel,
   input wire logic [sctr_pkg::DATA_W-1:0] regWrData,
   input wire logic [2:0] coreState,
   input wire logic [3:0] coreError,
   input wire logic loadReady,
   output logic [sctr_pkg::DATA_W-1:0] regRdData,
   output logic regRdValid,
   output logic cmdValid,
   output logic [7:0] cmdCode,
   output logic [7:0] cmdParamByte,
   output logic [15:0] command_param_wide,
   output logic inShutdown,
   output logic loadStart,
   output logic [sctr_pkg::TRIG_W-1:0] loadTrigger,
   output logic [sctr_pkg::ID_W-1:0] module_identifier
);
   // Bank-level decode of the current access.
   logic ctrlHit;
   logic mapHit;
   logic statusWr;
   logic trigWr;
   logic cmdKnown;
   logic accept;
   // Read path registers.
   logic [sctr_pkg::DATA_W-1:0] rdData_q, rdData_d;
   logic rdValid_q, rdValid_d;
   // Command capture registers.
   logic cmdValid_q, cmdValid_d;
   logic [7:0] cmdCode_q, cmdCode_d;
   logic [7:0] cmdByte_q, cmdByte_d;
   logic [15:0] cmdWide_q, cmdWide_d;
   // Socket manager state as seen by this block.
   logic shutdown_q, shutdown_d;
   // Software trigger state.
   logic pending_q, pending_d;
   logic [sctr_pkg::TRIG_W-1:0] trig_q, trig_d;
   // Load hand-off registers.
   logic loadStart_q, loadStart_d;
   logic [sctr_pkg::TRIG_W-1:0] loadTrig_q, loadTrig_d;
   logic [sctr_pkg::ID_W-1:0] loadId_q, loadId_d;

   // Carrier to the map bank; the bank keeps its own storage array.
   sctr_map_if mapIf();

   // Decodes a command code; reserved codes are refused rather than trusted.
   function automatic logic isKnownCmd(input logic [7:0] code);
      return (code == sctr_pkg::CMD_SHUTDOWN) || (code == sctr_pkg::CMD_RESTART_QUIET) ||
             (code == sctr_pkg::CMD_RESTART_STATUS) || (code == sctr_pkg::CMD_PROCEED) ||
             (code == sctr_pkg::CMD_USER_CTRL);
   endfunction

   // Address decode for both banks.
   assign ctrlHit = (regBank == sctr_pkg::BANK_CTRL);
   assign mapHit = (regBank == sctr_pkg::BANK_MAP);
   assign statusWr = regWrEn && ctrlHit && (regSel == sctr_pkg::SEL_STATUS);
   assign trigWr = regWrEn && ctrlHit && (regSel == sctr_pkg::SEL_SWTRIG);
   assign cmdKnown = isKnownCmd(regWrData[sctr_pkg::CMD_HI:sctr_pkg::CMD_LO]);
   // A trigger is taken only while active and when the loader can start.
   assign accept = pending_q && !shutdown_q && loadReady;

   // Map bank connections.
   assign mapIf.wrEn = regWrEn && mapHit;
   assign mapIf.sel = regSel;
   assign mapIf.wrData = regWrData;
   assign mapIf.lookupIdx = trig_q;
   assign mapIf.shutdown = shutdown_q;

   sctr_map_bank i_sctr_map_bank (
      .mclk(mclk),
      .rst_n(rst_n),
      .mapIf(mapIf)
   );

   // Read path: status at the shared address, trigger register, or the map bank.
   always_comb begin
      rdData_d = sctr_pkg::RST_WORD;
      rdValid_d = regRdEn;
      if (regRdEn && ctrlHit && (regSel == sctr_pkg::SEL_STATUS)) begin
         // A read here never sees the command word, only status.
         rdData_d[sctr_pkg::SHUT_BIT] = shutdown_q;
         rdData_d[6:3] = coreError;
         rdData_d[2:0] = coreState;
      end else if (regRdEn && ctrlHit && (regSel == sctr_pkg::SEL_SWTRIG)) begin
         rdData_d[sctr_pkg::PEND_BIT] = pending_q;
         rdData_d[sctr_pkg::TRIG_W-1:0] = trig_q;
      end else if (regRdEn && mapHit) begin
         // The bank itself zeroes reads outside shutdown and unstored bits.
         rdData_d = mapIf.rdData;
      end
   end

   // Command capture: fields are latched together so they stay consistent.
   always_comb begin
      cmdValid_d = 1'b0;
      cmdCode_d = cmdCode_q;
      cmdByte_d = cmdByte_q;
      cmdWide_d = cmdWide_q;
      shutdown_d = shutdown_q;
      // Reserved codes fall through, so nothing is captured for them.
      if (statusWr && cmdKnown) begin
         cmdValid_d = 1'b1;
         cmdCode_d = regWrData[sctr_pkg::CMD_HI:sctr_pkg::CMD_LO];
         cmdByte_d = regWrData[sctr_pkg::BYTE_HI:sctr_pkg::BYTE_LO];
         cmdWide_d = regWrData[sctr_pkg::WIDE_HI:sctr_pkg::WIDE_LO];
         case (regWrData[sctr_pkg::CMD_HI:sctr_pkg::CMD_LO])
            sctr_pkg::CMD_SHUTDOWN: begin
               shutdown_d = 1'b1;
            end
            sctr_pkg::CMD_RESTART_QUIET, sctr_pkg::CMD_RESTART_STATUS: begin
               shutdown_d = 1'b0;
            end
            default: begin
               // Proceed and user control leave the state as it is.
               shutdown_d = shutdown_q;
            end
         endcase
      end
   end

   // Software trigger: a new write wins over both an old trigger and the pending clear of an acceptance.
   always_comb begin
      pending_d = pending_q;
      trig_d = trig_q;
      loadStart_d = 1'b0;
      loadTrig_d = loadTrig_q;
      loadId_d = loadId_q;
      // The acceptance is evaluated first so that a write below can override its pending clear; the load still starts.
      if (accept) begin
         pending_d = 1'b0;
         loadStart_d = 1'b1;
         loadTrig_d = trig_q;
         loadId_d = mapIf.lookupId;
      end
      if (trigWr) begin
         pending_d = 1'b1;
         trig_d = regWrData[sctr_pkg::TRIG_W-1:0];
      end
   end

   // Read path registers; the word is cleared under reset so no stale data leaks out.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdData_q <= sctr_pkg::RST_WORD;
         rdValid_q <= 1'b0;
      end else begin
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
      end
   end

   // Command registers; reset leaves the manager in shutdown so the map is open at once.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cmdValid_q <= 1'b0;
         cmdCode_q <= '0;
         cmdByte_q <= '0;
         cmdWide_q <= '0;
         shutdown_q <= sctr_pkg::RST_SHUTDOWN;
      end else begin
         cmdValid_q <= cmdValid_d;
         cmdCode_q <= cmdCode_d;
         cmdByte_q <= cmdByte_d;
         cmdWide_q <= cmdWide_d;
         shutdown_q <= shutdown_d;
      end
   end

   // Trigger and load hand-off registers.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pending_q <= sctr_pkg::RST_PENDING;
         trig_q <= '0;
         loadStart_q <= 1'b0;
         loadTrig_q <= '0;
         loadId_q <= '0;
      end else begin
         pending_q <= pending_d;
         trig_q <= trig_d;
         loadStart_q <= loadStart_d;
         loadTrig_q <= loadTrig_d;
         loadId_q <= loadId_d;
      end
   end

   // Every output comes straight from a flip-flop.
   assign regRdData = rdData_q;
   assign regRdValid = rdValid_q;
   assign cmdValid = cmdValid_q;
   assign cmdCode = cmdCode_q;
   assign cmdParamByte = cmdByte_q;
   assign command_param_wide = cmdWide_q;
   assign inShutdown = shutdown_q;
   assign loadStart = loadStart_q;
   assign loadTrigger = loadTrig_q;
   assign module_identifier = loadId_q;

   // Properties share one clock and one reset, so both are given once here.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   status_read_a: assert property (
      regRdEn && ctrlHit && regSel == sctr_pkg::SEL_STATUS
      |=> regRdValid && regRdData[sctr_pkg::SHUT_BIT] == $past(shutdown_q)
          && regRdData[31:8] == 24'h000000)
      else $error("status read does not show shutdown state");

   cmd_wide_a: assert property (
      statusWr && cmdKnown |=> cmdValid && command_param_wide == $past(regWrData[31:16]))
      else $error("wide command parameter not captured");

   cmd_byte_a: assert property (
      statusWr && cmdKnown |=> cmdParamByte == $past(regWrData[15:8])
                               && cmdCode == $past(regWrData[7:0]))
      else $error("byte parameter or code not captured");

   cmd_refuse_a: assert property (
      !(statusWr && cmdKnown) |=> !cmdValid && $stable(inShutdown))
      else $error("state changed without a defined command");

   shut_cmd_a: assert property (
      statusWr && regWrData[7:0] == sctr_pkg::CMD_SHUTDOWN |=> inShutdown)
      else $error("shutdown command did not enter shutdown");

   trig_pend_a: assert property (
      trigWr |=> pending_q && trig_q == $past(regWrData[sctr_pkg::TRIG_W-1:0]))
      else $error("trigger write did not raise pending");

   trig_read_a: assert property (
      regRdEn && ctrlHit && regSel == sctr_pkg::SEL_SWTRIG
      |=> regRdData[31] == $past(pending_q) && regRdData[30:sctr_pkg::TRIG_W] == '0)
      else $error("trigger register read is wrong");

   accept_clear_a: assert property (
      accept && !trigWr |=> !pending_q ##0 loadStart ##1 !loadStart)
      else $error("accepted trigger not cleared or start not a pulse");

   map_gate_a: assert property (
      regRdEn && mapHit && !shutdown_q |=> regRdData == 32'h0000_0000)
      else $error("map bank readable outside shutdown");

   load_id_a: assert property (
      accept |=> module_identifier == $past(mapIf.lookupId)
                 && loadTrigger == $past(trig_q))
      else $error("loaded identifier does not match map row");

   // Hold and precedence checks on the trigger hand-off and the command fields, and checks on the read word.
   set_wins_a: assert property (
      accept && trigWr |=> pending_q && loadStart
                           && trig_q == $past(regWrData[sctr_pkg::TRIG_W-1:0]))
      else $error("trigger write in accept cycle was lost");

   refused_hold_a: assert property (
      pending_q && (shutdown_q || !loadReady) |=> pending_q && !loadStart)
      else $error("refused trigger was dropped or started");

   read_idle_a: assert property (
      !regRdEn |=> !regRdValid && regRdData == 32'h0000_0000)
      else $error("read data or valid outside a read");

   status_fields_a: assert property (
      regRdEn && ctrlHit && regSel == sctr_pkg::SEL_STATUS
      |=> regRdData[6:0] == $past({coreError, coreState}))
      else $error("status read does not show loader state and error");

   map_upper_a: assert property (
      regRdEn && mapHit |=> regRdData[31:sctr_pkg::ID_W] == '0)
      else $error("map read shows unstored bits");

   load_hold_a: assert property (
      !accept |=> $stable(loadTrigger) && $stable(module_identifier))
      else $error("load outputs changed without an accept");

   cmd_hold_a: assert property (
      !(statusWr && cmdKnown)
      |=> $stable(command_param_wide) && $stable(cmdParamByte) && $stable(cmdCode))
      else $error("command fields changed without a command");

   trig_hold_a: assert property (
      !trigWr |=> $stable(trig_q))
      else $error("trigger number changed without a write");
endmodule

// [socket_command_trigger_regs_tb.sv]
// Self-checking testbench for the socket command, trigger and map registers.
`timescale 1ns/1ps
module socket_command_trigger_regs_tb;
   logic mclk = 1'b0; // 25 MHz clock.
   logic rst_n = 1'b0; // Synchronous active-low reset.
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [1:0] regBank = 2'h0;
   logic [8:0] regSel = 9'h000;
   logic [31:0] regWrData = 32'h0000_0000;
   logic [2:0] coreState = 3'h0;
   logic [3:0] coreError = 4'h0;
   logic loadReady = 1'b0;
   logic [31:0] regRdData;
   logic regRdValid, cmdValid, inShutdown, loadStart;
   logic [7:0] cmdCode, cmdParamByte;
   logic [15:0] command_param_wide;
   logic [3:0] loadTrigger, module_identifier;
   logic [40:0] cmdSeen; // Command outputs packed as the notes order them.
   logic [7:0] loadSeen; // Load outputs packed as trigger then identifier.
   // Expected results, noted by the drivers and consumed by the monitor.
   logic [63:0] rdQ[$];
   logic [63:0] cmdQ[$];
   logic [63:0] loadQ[$];
   logic [3:0] mapV[16]; // Bench copy of the map contents.
   logic expShut = 1'b1; // Reset leaves the manager in shutdown.
   int failures = 0;
   int numChecks = 0;

   sctr_socket_regs i_sctr_socket_regs (.mclk(mclk), .rst_n(rst_n), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regBank(regBank), .regSel(regSel), .regWrData(regWrData),
      .coreState(coreState), .coreError(coreError), .loadReady(loadReady),
      .regRdData(regRdData), .regRdValid(regRdValid), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .cmdParamByte(cmdParamByte),
      .command_param_wide(command_param_wide), .inShutdown(inShutdown),
      .loadStart(loadStart), .loadTrigger(loadTrigger),
      .module_identifier(module_identifier));

   assign cmdSeen = {inShutdown, cmdCode, cmdParamByte, command_param_wide};
   assign loadSeen = {loadTrigger, module_identifier};

   // Clock generation, half a period between edges.
   always #20 mclk = ~mclk;

   // Compares one value and counts the outcome.
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic close_out;
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // One write pulse; the strobe drops after the taking edge, never in its time step.
   task automatic wr(input logic [1:0] b, input logic [8:0] s, input logic [31:0] d);
      @(posedge mclk);
      #1;
      regBank = b;
      regSel = s;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge mclk);
      #1;
      regWrEn = 1'b0;
   endtask

   // One read pulse with its expected word noted first.
   task automatic rd(input logic [1:0] b, input logic [8:0] s, input logic [31:0] e);
      rdQ.push_back(64'(e));
      @(posedge mclk);
      #1;
      regBank = b;
      regSel = s;
      regRdEn = 1'b1;
      @(posedge mclk);
      #1;
      regRdEn = 1'b0;
   endtask

   // Status word as software should see it, built from the bench state.
   function automatic logic [31:0] statusWord();
      return {24'h000000, expShut, coreError, coreState};
   endfunction

   // Command write; only the five defined codes expect an answer.
   task automatic cmd(input logic [7:0] c, input logic [7:0] pb, input logic [15:0] pw);
      if (c <= 8'h04) begin
         if (c == sctr_pkg::CMD_SHUTDOWN) expShut = 1'b1;
         if (c == sctr_pkg::CMD_RESTART_QUIET || c == sctr_pkg::CMD_RESTART_STATUS) begin
            expShut = 1'b0;
         end
         cmdQ.push_back(64'({expShut, c, pb, pw}));
      end
      wr(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_STATUS, {pw, pb, c});
   endtask

   // Waits, bounded, until every noted result has been seen.
   task automatic drain;
      int n;
      n = 0;
      while ((rdQ.size() + cmdQ.size() + loadQ.size()) != 0 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      if ((rdQ.size() + cmdQ.size() + loadQ.size()) != 0) begin
         chk("drain timeout", 64'h1, 64'h0);
         close_out();
      end
   endtask

   // Monitor: any result pulse with no note waiting is itself a mismatch.
   always @(posedge mclk) begin
      if (rst_n === 1'b1) begin
         if (regRdValid === 1'b1) begin
            if (rdQ.size() == 0) chk("spurious read", 64'h1, 64'h0);
            else chk("read", 64'(regRdData), rdQ.pop_front());
         end
         if (cmdValid === 1'b1) begin
            if (cmdQ.size() == 0) chk("spurious command", 64'h1, 64'h0);
            else chk("command", 64'(cmdSeen), cmdQ.pop_front());
         end
         if (loadStart === 1'b1) begin
            if (loadQ.size() == 0) chk("spurious load", 64'h1, 64'h0);
            else chk("load", 64'(loadSeen), loadQ.pop_front());
         end
      end
   end

   // Main sequence.
   initial begin
      logic [31:0] d;
      logic [3:0] t1, t2;
      void'($urandom(32'hb25fefd5));
      coreState = 3'($urandom);
      coreError = 4'($urandom);
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      rd(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_STATUS, statusWord());
      // Fill the map with random words; the last row repeats row 0.
      for (int i = 0; i < 16; i++) begin
         d = $urandom;
         if (i == 15) d[3:0] = mapV[0];
         mapV[i] = d[3:0];
         wr(sctr_pkg::BANK_MAP, 9'(i), d);
      end
      // Row 16 lies beyond the allocation and must read zero.
      for (int i = 0; i < 17; i++) begin
         rd(sctr_pkg::BANK_MAP, 9'(i), (i < 16) ? {28'h0, mapV[4'(i)]} : 32'h0);
      end
      // Leaving shutdown closes the map to software.
      cmd(sctr_pkg::CMD_RESTART_QUIET, 8'($urandom), 16'($urandom));
      rd(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_STATUS, statusWord());
      rd(sctr_pkg::BANK_MAP, 9'h003, 32'h0);
      wr(sctr_pkg::BANK_MAP, 9'h003, {28'h0, ~mapV[3]});
      // Two trigger writes while the loader is busy; the second replaces the first.
      t1 = 4'($urandom);
      t2 = ~t1; // Always differs from the first, so the replacement is visible.
      d = $urandom;
      wr(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_SWTRIG, {1'b1, d[26:0], t1});
      wr(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_SWTRIG, {1'b0, d[30:4], t2});
      rd(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_SWTRIG, {1'b1, 27'h0, t2});
      drain();
      loadQ.push_back(64'({t2, mapV[t2]}));
      @(posedge mclk);
      #1;
      loadReady = 1'b1;
      repeat (3) @(posedge mclk);
      rd(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_SWTRIG, {1'b0, 27'h0, t2});
      chk("held trigger", 64'(loadSeen), 64'({t2, mapV[t2]}));
      // Back in shutdown the ignored write must not have changed row 3.
      cmd(sctr_pkg::CMD_SHUTDOWN, 8'($urandom), 16'($urandom));
      rd(sctr_pkg::BANK_MAP, 9'h003, {28'h0, mapV[3]});
      cmd(sctr_pkg::CMD_PROCEED, 8'($urandom), 16'($urandom));
      cmd(sctr_pkg::CMD_USER_CTRL, 8'($urandom), 16'($urandom));
      // Software only ever issues defined codes; two of them are picked at random.
      cmd(8'($urandom % 5), 8'($urandom), 16'($urandom));
      cmd(8'($urandom % 5), 8'($urandom), 16'($urandom));
      cmd(sctr_pkg::CMD_RESTART_STATUS, 8'($urandom), 16'($urandom));
      rd(sctr_pkg::BANK_CTRL, sctr_pkg::SEL_STATUS, statusWord());
      rd(2'h2, 9'h000, 32'h0);
      drain();
      close_out();
   end
endmodule
